// ===== pl3ec_buf.v
// message octet buffer with registered read data
`timescale 1ns/1ps
module pl3ec_buf #(
    parameter DW = 8,
    parameter AW = 6
) (
    // clock
    input  wire          clk,
    // write side
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    // read side
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data
);

reg [DW-1:0] mem [0:(1<<AW)-1];

always @(posedge clk) begin
    if (wr_en) begin
        mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
end

endmodule

// ===== pl3ec_checker.v
// receive-side error checker for layer-3 signalling messages
// Overview of operation
// [RQ1] messages carry discriminator, port address, message type
// [RQ2] under four octets: protocol error, discard
// [RQ3] over three optional elements: truncate after third
// [RQ4] checks in precedence order, no state change
// [RQ5] only surviving messages are handed on
// [RQ6] discard means no action on any content
// [RQ7] at most one status report per message
// [RQ8] status cause is highest-precedence error found
// [RQ9] wrong discriminator: internal error, discard
// [RQ10] address badly coded, unknown or absent: error
// [RQ11] access side address error: discard, report
// [RQ12] exchange side address error: discard, no report
// [RQ13] port address selects the analogue port
// [RQ14] outgoing reports go by link send request
// [RQ15] line signal elements forwarded uninterpreted
// [RQ16] unknown type: discard, error, report on access
// [RQ17] repeated optionals removed, error, processing continues
// [RQ18] one verdict per fully received message
`timescale 1ns/1ps
`include "pl3ec_consts.vh"
module pl3ec_checker #(
    parameter AW        = 6,
    parameter NUM_PORTS = 32,
    parameter [7:0] PD_CODE     = 8'h01,
    parameter [7:0] MT_LO       = 8'h00,
    parameter [7:0] MT_HI       = 8'h0F,
    parameter [7:0] LINE_SIG_ID = 8'h10
) (
    // clock and reset
    input  wire                 clk,
    input  wire                 rstn,
    // configuration
    input  wire                 an_side,
    input  wire [NUM_PORTS-1:0] port_exists,
    // received octet stream
    input  wire                 msg_valid,
    input  wire [7:0]           msg_data,
    input  wire                 msg_last,
    output wire                 msg_ready,
    // verdict
    output reg                  verdict_valid,
    output reg  [1:0]           verdict,
    output reg  [AW:0]          keep_len,
    output reg  [2:0]           removed_mask,
    output reg  [2:0]           line_sig_mask,
    output reg  [14:0]          port_index,
    output wire                 busy,
    // error indications
    output reg                  mgmt_protocol_error,
    output reg                  internal_error,
    // status report towards the link
    output reg                  link_send_request,
    input  wire                 link_send_ack,
    output reg  [2:0]           status_cause,
    output reg  [14:0]          status_addr,
    output reg                  status_state_na
);

localparam [2:0] S_RX    = 3'h0;
localparam [2:0] S_FETCH = 3'h1;
localparam [2:0] S_USE   = 3'h2;
localparam [2:0] S_DONE  = 3'h3;
localparam [2:0] S_SEND  = 3'h4;
localparam [AW:0] DEPTH  = {1'b1, {AW{1'b0}}};

// message type recognition
function mt_known;
    input [7:0] mt;
    begin
        mt_known = (mt >= MT_LO) && (mt <= MT_HI);
    end
endfunction

// an id already seen among the first n kept elements
function id_seen;
    input [23:0] ids;
    input [1:0]  n;
    input [7:0]  id;
    begin
        id_seen = ((n > 2'h0) && (ids[7:0] == id))
               || ((n > 2'h1) && (ids[15:8] == id))
               || ((n > 2'h2) && (ids[23:16] == id));
    end
endfunction

reg  [2:0]    state_reg;
reg  [2:0]    field_reg;
reg  [AW:0]   len_reg;
reg  [AW:0]   ptr_reg;
reg  [7:0]    addr_hi_reg;
reg  [1:0]    elem_cnt_reg;
reg  [23:0]   ids_reg;
reg           discard_reg;
reg           int_err_reg;
reg           report_reg;
reg  [2:0]    cause_reg;
wire [7:0]    rd_data;
wire [14:0]   addr_val;
wire          addr_ok;
wire [AW:0]   elem_end;
wire          wr_en;

assign msg_ready = (state_reg == S_RX);
assign busy      = ~msg_ready; // [RQ4]
assign wr_en     = msg_valid && msg_ready && (len_reg < DEPTH);
assign addr_val  = {addr_hi_reg, rd_data[7:1]};
// [RQ10]
assign addr_ok   = rd_data[0] && (addr_val < NUM_PORTS)
                && port_exists[addr_val[4:0]];
assign elem_end  = ptr_reg + {{AW{1'b0}}, 1'b1} + rd_data[AW:0];

pl3ec_buf #(
    .DW      (8),
    .AW      (AW)
) u_buf (
    .clk     (clk),
    .wr_en   (wr_en),
    .wr_addr (len_reg[AW-1:0]),
    .wr_data (msg_data),
    .rd_addr (ptr_reg[AW-1:0]),
    .rd_data (rd_data)
);

////////////////////////////////////////////////////////////////////////////
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        state_reg           <= S_RX;
        field_reg           <= `PL3EC_F_PD;
        len_reg             <= {(AW+1){1'b0}};
        ptr_reg             <= {(AW+1){1'b0}};
        addr_hi_reg         <= 8'h00;
        elem_cnt_reg        <= 2'h0;
        ids_reg             <= 24'h000000;
        discard_reg         <= 1'b0;
        int_err_reg         <= 1'b0;
        report_reg          <= 1'b0;
        cause_reg           <= `PL3EC_C_NONE;
        verdict_valid       <= 1'b0;
        verdict             <= `PL3EC_V_DISCARD;
        keep_len            <= {(AW+1){1'b0}};
        removed_mask        <= 3'h0;
        line_sig_mask       <= 3'h0;
        port_index          <= 15'h0000;
        mgmt_protocol_error <= 1'b0;
        internal_error      <= 1'b0;
        link_send_request   <= 1'b0;
        status_cause        <= `PL3EC_C_NONE;
        status_addr         <= 15'h0000;
        status_state_na     <= 1'b0;
    end else begin
        verdict_valid       <= 1'b0;
        mgmt_protocol_error <= 1'b0;
        internal_error      <= 1'b0;
        case (state_reg)
        S_RX: begin
            if (msg_valid) begin
                if (len_reg < DEPTH) begin
                    len_reg <= len_reg + {{AW{1'b0}}, 1'b1};
                end
                if (msg_last) begin
                    ptr_reg      <= `PL3EC_OFS_PD;
                    field_reg    <= `PL3EC_F_PD;
                    elem_cnt_reg <= 2'h0;
                    ids_reg      <= 24'h000000;
                    discard_reg  <= 1'b0;
                    int_err_reg  <= 1'b0;
                    report_reg   <= 1'b0;
                    cause_reg    <= `PL3EC_C_NONE;
                    removed_mask  <= 3'h0;
                    line_sig_mask <= 3'h0;
                    keep_len     <= len_reg + {{AW{1'b0}}, 1'b1};
                    // [RQ1] [RQ2]
                    if (len_reg + {{AW{1'b0}}, 1'b1} < `PL3EC_MIN_LEN) begin
                        mgmt_protocol_error <= 1'b1;
                        verdict_valid       <= 1'b1;
                        verdict             <= `PL3EC_V_DISCARD;
                        len_reg             <= {(AW+1){1'b0}};
                    end else begin
                        state_reg <= S_FETCH;
                    end
                end
            end
        end
        S_FETCH: begin
            state_reg <= S_USE;
        end
        S_USE: begin
            state_reg <= S_FETCH;
            ptr_reg   <= ptr_reg + {{AW{1'b0}}, 1'b1};
            case (field_reg)
            `PL3EC_F_PD: begin
                field_reg <= `PL3EC_F_AHI;
                if (rd_data != PD_CODE) begin // [RQ9]
                    discard_reg <= 1'b1;
                    int_err_reg <= 1'b1;
                    state_reg   <= S_DONE;
                end
            end
            `PL3EC_F_AHI: begin
                addr_hi_reg <= rd_data;
                field_reg   <= `PL3EC_F_ALO;
            end
            `PL3EC_F_ALO: begin
                status_addr <= addr_val;
                port_index  <= addr_val; // [RQ13]
                field_reg   <= `PL3EC_F_MT;
                if (!addr_ok) begin
                    discard_reg <= 1'b1;
                    int_err_reg <= 1'b1;
                    report_reg  <= an_side; // [RQ11] [RQ12]
                    cause_reg   <= `PL3EC_C_ADDR;
                    state_reg   <= S_DONE;
                end
            end
            `PL3EC_F_MT: begin
                field_reg <= `PL3EC_F_EID;
                if (!mt_known(rd_data)) begin // [RQ16]
                    discard_reg <= 1'b1;
                    int_err_reg <= 1'b1;
                    report_reg  <= an_side;
                    cause_reg   <= `PL3EC_C_MSG_TYPE;
                    state_reg   <= S_DONE;
                end else if (`PL3EC_OFS_MT + 7'h01 >= len_reg) begin
                    state_reg <= S_DONE;
                end
            end
            `PL3EC_F_EID: begin
                field_reg <= `PL3EC_F_ELEN;
                if (elem_cnt_reg == `PL3EC_MAX_OPT) begin // [RQ3]
                    keep_len    <= ptr_reg;
                    int_err_reg <= 1'b1;
                    report_reg  <= an_side;
                    if (cause_reg == `PL3EC_C_NONE) begin // [RQ8]
                        cause_reg <= `PL3EC_C_REP_OPT;
                    end
                    state_reg   <= S_DONE;
                end else begin
                    ids_reg[elem_cnt_reg*8 +: 8] <= rd_data;
                    if (id_seen(ids_reg, elem_cnt_reg, rd_data)) begin
                        // [RQ17]
                        removed_mask[elem_cnt_reg] <= 1'b1;
                        int_err_reg <= 1'b1;
                        report_reg  <= an_side;
                        if (cause_reg == `PL3EC_C_NONE) begin
                            cause_reg <= `PL3EC_C_REP_OPT;
                        end
                    end else if (rd_data == LINE_SIG_ID) begin
                        line_sig_mask[elem_cnt_reg] <= 1'b1; // [RQ15]
                    end
                end
            end
            `PL3EC_F_ELEN: begin
                field_reg    <= `PL3EC_F_EID;
                elem_cnt_reg <= elem_cnt_reg + 2'h1;
                ptr_reg      <= elem_end;
                if (elem_end >= len_reg) begin
                    state_reg <= S_DONE;
                end
            end
            default: begin
                state_reg <= S_DONE;
            end
            endcase
        end
        S_DONE: begin
            // [RQ18] single verdict, [RQ5] [RQ6]
            verdict_valid  <= 1'b1;
            internal_error <= int_err_reg;
            len_reg        <= {(AW+1){1'b0}};
            if (discard_reg) begin
                verdict <= `PL3EC_V_DISCARD;
            end else if (int_err_reg) begin
                verdict <= `PL3EC_V_REMOVED;
            end else begin
                verdict <= `PL3EC_V_CONTINUE;
            end
            if (report_reg) begin // [RQ7]
                status_cause      <= cause_reg;
                status_state_na   <= (cause_reg == `PL3EC_C_ADDR);
                link_send_request <= 1'b1; // [RQ14]
                state_reg         <= S_SEND;
            end else begin
                state_reg <= S_RX;
            end
        end
        S_SEND: begin
            if (link_send_ack) begin
                link_send_request <= 1'b0;
                state_reg         <= S_RX;
            end
        end
        default: begin
            state_reg <= S_RX;
        end
        endcase
    end
end

endmodule

// ===== pl3ec_checker_props.sv
// assertion checker for the layer-3 message error checker
`timescale 1ns/1ps
`include "pl3ec_consts.vh"
module pl3ec_checker_props (
    // clock and reset
    input wire        clk,
    input wire        rstn,
    // configuration and input side
    input wire        an_side,
    input wire        msg_ready,
    // verdict
    input wire        verdict_valid,
    input wire [1:0]  verdict,
    input wire [2:0]  removed_mask,
    input wire [14:0] port_index,
    input wire        mgmt_protocol_error,
    input wire        internal_error,
    // status report
    input wire        link_send_request,
    input wire        link_send_ack,
    input wire [2:0]  status_cause,
    input wire [14:0] status_addr,
    input wire        status_state_na
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_short_discard: assert property (
        mgmt_protocol_error |-> verdict_valid && !internal_error
        && verdict == `PL3EC_V_DISCARD) else $error("short not dropped");
    chk_report_an_only: assert property (
        $rose(link_send_request) |-> verdict_valid && an_side)
        else $error("report without verdict or on exchange side");
    chk_one_report: assert property (
        link_send_request && link_send_ack |=> !link_send_request)
        else $error("request kept after ack");
    chk_req_held: assert property (
        link_send_request && !link_send_ack
        |=> link_send_request && $stable(status_cause))
        else $error("request or cause dropped before ack");
    chk_busy_checking: assert property (
        verdict_valid && !mgmt_protocol_error |-> !$past(msg_ready))
        else $error("verdict without a busy check phase");
    chk_busy_report: assert property (
        link_send_request |-> !msg_ready) else $error("ready during report");
    chk_addr_report: assert property (
        $rose(link_send_request) && status_cause == `PL3EC_C_ADDR
        |-> status_state_na && internal_error && status_addr == port_index
        && verdict == `PL3EC_V_DISCARD) else $error("bad address report");
    chk_removed_verdict: assert property (
        verdict_valid && removed_mask != 3'h0
        |-> verdict == `PL3EC_V_REMOVED && internal_error)
        else $error("removal without error");
    chk_clean_continue: assert property (
        verdict_valid && verdict == `PL3EC_V_CONTINUE
        |-> !internal_error && !link_send_request)
        else $error("clean message flagged");
    cov_short: cover property (mgmt_protocol_error);
    cov_report: cover property (link_send_request && link_send_ack);
    cov_removed: cover property (verdict_valid && verdict == 2'h2);
endmodule
bind pl3ec_checker pl3ec_checker_props u_props (.clk(clk), .rstn(rstn),
    .an_side(an_side), .msg_ready(msg_ready),
    .verdict_valid(verdict_valid), .verdict(verdict),
    .removed_mask(removed_mask), .port_index(port_index),
    .mgmt_protocol_error(mgmt_protocol_error),
    .internal_error(internal_error), .link_send_request(link_send_request),
    .link_send_ack(link_send_ack), .status_cause(status_cause),
    .status_addr(status_addr), .status_state_na(status_state_na));

// ===== pl3ec_checker_test.sv
// self-checking testbench of the layer-3 message error checker
`timescale 1ns/1ps
`include "pl3ec_consts.vh"
module pl3ec_checker_test;
    logic        clk = 0, rstn = 0, an_side = 0;
    logic        msg_valid = 0, msg_last = 0;
    logic [7:0]  msg_data = 8'h00;
    logic [3:0]  ack_dly = 4'h0;
    wire         msg_ready, verdict_valid, busy, mgmt_protocol_error;
    wire         internal_error, link_send_request, link_send_ack;
    wire         status_state_na;
    wire [1:0]   verdict;
    wire [6:0]   keep_len;
    wire [2:0]   removed_mask, line_sig_mask, status_cause;
    wire [14:0]  port_index, status_addr;
    logic [7:0]  q[$];
    logic        req_d = 0;
    int          fails = 0, n_checks = 0, reqs = 0, nreq, cyc = 0;
    pl3ec_checker dut (.clk(clk), .rstn(rstn), .an_side(an_side),
        .port_exists(32'h0000007F), .msg_valid(msg_valid),
        .msg_data(msg_data), .msg_last(msg_last), .msg_ready(msg_ready),
        .verdict_valid(verdict_valid), .verdict(verdict),
        .keep_len(keep_len), .removed_mask(removed_mask),
        .line_sig_mask(line_sig_mask), .port_index(port_index),
        .busy(busy), .mgmt_protocol_error(mgmt_protocol_error),
        .internal_error(internal_error),
        .link_send_request(link_send_request),
        .link_send_ack(link_send_ack), .status_cause(status_cause),
        .status_addr(status_addr), .status_state_na(status_state_na));
    pl3ec_link_model link (.clk(clk), .rstn(rstn), .dly(ack_dly),
        .link_send_request(link_send_request),
        .link_send_ack(link_send_ack));
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        req_d <= link_send_request;
        if (link_send_request && !req_d)
            reqs = reqs + 1;
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            report_and_stop;
        end
    end
    ////////////////////////////////////////////////////////////////////
    task report_and_stop;
        if (fails == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // send q whole, capture the verdict, wait out any report
    task automatic run(input logic an);
        int r0;
        r0 = reqs;
        @(posedge clk);
        while (!msg_ready)
            @(posedge clk);
        an_side <= an;
        foreach (q[i]) begin
            msg_valid <= 1'b1;
            msg_data  <= q[i];
            msg_last  <= (i == q.size() - 1);
            @(posedge clk);
        end
        msg_valid <= 1'b0;
        msg_last  <= 1'b0;
        // pulses stand from one edge to the next: look mid-cycle
        @(negedge clk);
        chk(busy, q.size() >= 4);
        while (!verdict_valid)
            @(negedge clk);
        chk(mgmt_protocol_error, q.size() < 4);
        while (link_send_request)
            @(posedge clk);
        nreq = reqs - r0;
    endtask
    ////////////////////////////////////////////////////////////////////
    task t_short;
        q = '{8'h01, 8'h00, 8'h0B};
        run(1'b1);
        chk(verdict, `PL3EC_V_DISCARD);
        chk(nreq, 0);
    endtask
    task t_pd;
        q = '{8'h02, 8'h00, 8'h0B, 8'h01};
        run(1'b1);
        chk(verdict, `PL3EC_V_DISCARD);
        chk(internal_error, 1);
        chk(nreq, 0);
    endtask
    task t_good;
        q = '{8'h01, 8'h00, 8'h0B, 8'h01};
        run(1'b1);
        chk(verdict, `PL3EC_V_CONTINUE);
        chk(port_index, 5);
        chk(nreq, 0);
    endtask
    // unknown port and unknown type together, slow acknowledge
    task t_addr;
        ack_dly = 4'h5;
        q = '{8'h01, 8'h00, 8'h0F, 8'h20};
        run(1'b1);
        chk(status_cause, `PL3EC_C_ADDR);
        chk(status_addr, 7);
        chk(status_state_na, 1);
        chk(nreq, 1);
        ack_dly = 4'h0;
        run(1'b0);
        chk(internal_error, 1);
        chk(nreq, 0);
        // address coding bit clear on an existing port
        q = '{8'h01, 8'h00, 8'h0A, 8'h01};
        run(1'b1);
        chk(verdict, `PL3EC_V_DISCARD);
        chk(status_cause, `PL3EC_C_ADDR);
        chk(status_addr, 5);
        chk(nreq, 1);
    endtask
    task t_repeat;
        q = '{8'h01, 8'h00, 8'h0B, 8'h01, 8'h20, 8'h00, 8'h20, 8'h00};
        run(1'b0);
        chk(verdict, `PL3EC_V_REMOVED);
        chk(removed_mask, 3'h2);
        chk(internal_error, 1);
        chk(nreq, 0);
    endtask
    task t_type;
        q = '{8'h01, 8'h00, 8'h0B, 8'h20};
        run(1'b1);
        chk(verdict, `PL3EC_V_DISCARD);
        chk(status_cause, `PL3EC_C_MSG_TYPE);
    endtask
    task t_trunc;
        q = '{8'h01, 8'h00, 8'h0B, 8'h01, 8'h20, 8'h00, 8'h21, 8'h00,
              8'h22, 8'h00, 8'h23, 8'h00};
        run(1'b1);
        chk(verdict, `PL3EC_V_REMOVED);
        chk(keep_len, 10);
        chk(status_cause, `PL3EC_C_REP_OPT);
        chk(nreq, 1);
    endtask
    task t_line;
        q = '{8'h01, 8'h00, 8'h0B, 8'h01, 8'h10, 8'h01, 8'h55};
        run(1'b0);
        chk(verdict, `PL3EC_V_CONTINUE);
        chk(line_sig_mask, 3'h1);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_short;
        t_pd;
        t_good;
        t_addr;
        t_type;
        t_trunc;
        t_repeat;
        t_line;
        report_and_stop;
    end
endmodule

// ===== pl3ec_consts.vh
// constants of the layer-3 message error checker
`ifndef PL3EC_CONSTS_VH
`define PL3EC_CONSTS_VH

// minimum message length in octets
`define PL3EC_MIN_LEN      7'h04
// most optional elements kept
`define PL3EC_MAX_OPT      2'h3
// header octet offsets
`define PL3EC_OFS_PD       7'h00
`define PL3EC_OFS_MT       7'h03
// read phases of the header and element walk
`define PL3EC_F_PD         3'h0
`define PL3EC_F_AHI        3'h1
`define PL3EC_F_ALO        3'h2
`define PL3EC_F_MT         3'h3
`define PL3EC_F_EID        3'h4
`define PL3EC_F_ELEN       3'h5
// verdict codes
`define PL3EC_V_DISCARD    2'h0
`define PL3EC_V_CONTINUE   2'h1
`define PL3EC_V_REMOVED    2'h2
// status report causes
`define PL3EC_C_NONE       3'h0
`define PL3EC_C_ADDR       3'h1
`define PL3EC_C_MSG_TYPE   3'h2
`define PL3EC_C_REP_OPT    3'h3

`endif

// ===== pl3ec_link_model.sv
// data link layer model that acknowledges status reports
`timescale 1ns/1ps
module pl3ec_link_model (
    // clock and reset
    input  wire       clk,
    input  wire       rstn,
    // link send handshake
    input  wire       link_send_request,
    output reg        link_send_ack,
    // cycles to hold off the acknowledge
    input  wire [3:0] dly
);
    reg [3:0] wait_reg;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link_send_ack <= 1'b0;
            wait_reg      <= 4'h0;
        end else if (link_send_request && !link_send_ack) begin
            link_send_ack <= (wait_reg == dly);
            wait_reg      <= wait_reg + 4'h1;
        end else begin
            link_send_ack <= 1'b0;
            wait_reg      <= 4'h0;
        end
    end
endmodule
